// ### core/slcd_strap_latch.v
// Strap capture, decode and AHB-Lite status registers
`timescale 1ns/100ps
`default_nettype none
`include "slcd_consts.vh"

// Notes on behaviour
// - Capture straps at reset release, then hold
// - Positive line strap one means disabled
// - Negative line strap one means disabled
// - Port disabled when both straps high or its control bit is set
// - Disabled USB2 side also disables USB3 side
// - Fixed strap: 200k levels give none, port1
// - Fixed strap: 10k levels give ports 1-2, 1-3
// - Fixed strap: 10 ohm levels give 1-4, 1-6
// - Charge strap: 200k levels give none, port1
// - Charge strap: 10k levels give 1-2, 1-3
// - Charge strap: 10 ohm levels give 1-4, 1-6
// - Mode straps sampled with others set mode
// - Lower two mode straps pick pin functions
// - Third mode strap is ignored entirely
// - Mode2 200k down, mode1 10k down selects config3
module slcd_strap_latch (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire ext_reset_n,
  input wire [5:0] port_pos_line_disable_strap,
  input wire [5:0] port_neg_line_disable_strap,
  input wire [2:0] fixed_port_count_strap,
  input wire [2:0] charge_port_count_strap,
  input wire [2:0] mode_strap1_level,
  input wire [2:0] mode_strap2_level,
  output reg [5:0] port_disable,
  output reg [5:0] port_ss_disable,
  output reg [5:0] fixed_port_mask,
  output reg [5:0] charge_port_mask,
  output reg [1:0] pf_config_sel,
  output reg strap_invalid,
  output reg config_captured
);

  // ------------------------------------------------------------
  // Strap synchronisers
  // ------------------------------------------------------------
  wire [23:0] strap_raw; // All strap pins in one vector
  wire [23:0] strap_held; // Filtered strap levels
  wire ext_reset_held; // Filtered external reset level

  assign strap_raw = {mode_strap2_level, mode_strap1_level, charge_port_count_strap,
                      fixed_port_count_strap, port_neg_line_disable_strap, port_pos_line_disable_strap};

  // Straps pass four flops (three stages and the filter) before use
  slcd_sync #(.WIDTH(24), .INIT(24'h000000)) u_strap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(strap_raw),
    .held(strap_held)
  );

  // External reset starts high so power-on gives no false edge
  slcd_sync #(.WIDTH(1), .INIT(1'b1)) u_ext_reset_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(ext_reset_n),
    .held(ext_reset_held)
  );

  wire [5:0] pos_held; // Positive line disable straps
  wire [5:0] neg_held; // Negative line disable straps
  wire [2:0] fixed_held; // Fixed port strap level
  wire [2:0] charge_held; // Charge port strap level
  wire [2:0] mode1_held; // Lower mode strap level
  wire [2:0] mode2_held; // Upper used mode strap level

  // Split the filtered vector back into its strap groups
  assign pos_held = strap_held[5:0];
  assign neg_held = strap_held[11:6];
  assign fixed_held = strap_held[14:12];
  assign charge_held = strap_held[17:15];
  assign mode1_held = strap_held[20:18];
  assign mode2_held = strap_held[23:21];

  // ------------------------------------------------------------
  // Capture trigger
  // ------------------------------------------------------------
  reg [2:0] settle_count; // Cycles since reset release
  reg ext_reset_prev; // Last filtered external reset
  reg settle_done; // Power-on capture already taken
  wire capture; // One-cycle capture pulse

  // Wait for the chain to fill after power-on, then fire once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_count <= 3'h0;
      settle_done <= 1'b0;
      ext_reset_prev <= 1'b1;
    end else begin
      // Previous filtered level for the rising edge detect
      ext_reset_prev <= ext_reset_held;
      // Count up once after each chip reset, then stop
      if (!settle_done) begin
        if (settle_count == `SLCD_SETTLE_CYCLES) begin
          settle_done <= 1'b1;
        end else begin
          settle_count <= settle_count + 3'h1;
        end
      end
    end
  end

  // Power-on capture, or rising edge of external reset
  // A low external reset level alone changes nothing
  assign capture = (!settle_done && settle_count == `SLCD_SETTLE_CYCLES) ||
                   (ext_reset_held && !ext_reset_prev);

  // ------------------------------------------------------------
  // Captured raw strap values
  // ------------------------------------------------------------
  reg [5:0] pos_cap; // Captured positive line straps
  reg [5:0] neg_cap; // Captured negative line straps
  reg [2:0] fixed_cap; // Captured fixed port level
  reg [2:0] charge_cap; // Captured charge port level
  reg [2:0] mode1_cap; // Captured lower mode level
  reg [2:0] mode2_cap; // Captured upper mode level

  // Values are taken on capture and held until the next one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_cap <= 6'h00;
      neg_cap <= 6'h00;
      fixed_cap <= `SLCD_LVL_200K_DOWN;
      charge_cap <= `SLCD_LVL_200K_DOWN;
      mode1_cap <= `SLCD_LVL_200K_DOWN;
      mode2_cap <= `SLCD_LVL_200K_DOWN;
    end else if (capture) begin
      // Take every strap group in the same cycle
      pos_cap <= pos_held;
      neg_cap <= neg_held;
      fixed_cap <= fixed_held;
      charge_cap <= charge_held;
      mode1_cap <= mode1_held;
      mode2_cap <= mode2_held;
    end
  end

  // ------------------------------------------------------------
  // Decode of captured values
  // ------------------------------------------------------------
  wire [5:0] fixed_dec; // Non-removable port mask
  wire [5:0] charge_dec; // Charging detection port mask
  wire fixed_bad; // Fixed level out of range
  wire charge_bad; // Charge level out of range
  wire mode_ok; // Mode straps form the supported pair
  wire [5:0] strap_dis; // Ports disabled by straps
  reg [5:0] force_disable; // Software forced port disable

  // Level index to fixed port mask
  slcd_level_decode u_fixed_decode (
    .level(fixed_cap),
    .port_mask(fixed_dec),
    .invalid(fixed_bad)
  );

  // Level index to charging port mask
  slcd_level_decode u_charge_decode (
    .level(charge_cap),
    .port_mask(charge_dec),
    .invalid(charge_bad)
  );

  // A line reads disabled when its strap is one; port needs both
  assign strap_dis = pos_cap & neg_cap;

  // Only one pair of mode levels is supported; third strap unread
  assign mode_ok = (mode2_cap == `SLCD_LVL_200K_DOWN) &&
                   (mode1_cap == `SLCD_LVL_10K_DOWN);

  // Register the decoded settings so outputs come from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_disable <= `SLCD_MASK_RESET;
      port_ss_disable <= `SLCD_MASK_RESET;
      fixed_port_mask <= `SLCD_MASK_RESET;
      charge_port_mask <= `SLCD_MASK_RESET;
      pf_config_sel <= `SLCD_PFSEL_NONE;
      strap_invalid <= 1'b0;
    end else begin
      port_disable <= strap_dis | force_disable;
      // Superspeed side always follows the port disable
      port_ss_disable <= strap_dis | force_disable;
      fixed_port_mask <= fixed_dec;
      charge_port_mask <= charge_dec;
      if (mode_ok) begin
        pf_config_sel <= `SLCD_PFSEL_CONFIG3;
      end else begin
        pf_config_sel <= `SLCD_PFSEL_NONE;
      end
      // Any reserved level or unsupported mode pair flags it
      strap_invalid <= fixed_bad | charge_bad | !mode_ok;
    end
  end

  // Marks that at least one capture has happened
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_captured <= 1'b0;
    end else if (capture) begin
      config_captured <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  reg wr_pending; // Data phase of a write is open
  reg [7:0] wr_addr; // Offset of the pending write
  wire accept; // Address phase taken this cycle
  wire [7:0] req_addr; // Offset of the address phase
  wire mapped; // Upper address bits are zero

  // Transfer starts on NONSEQ or SEQ while the bus is ready
  assign accept = hsel && hready && htrans[1];
  assign req_addr = haddr[7:0];
  assign mapped = (haddr[31:8] == 24'h000000);
  assign hreadyout = 1'b1; // Always zero wait states
  assign hresp = 1'b0; // Always OKAY

  // Read data assembled from current state
  function [31:0] slcd_read;
    input [7:0] ofs;
    begin
      case (ofs)
        `SLCD_OFS_CTRL: slcd_read = {26'h0000000, force_disable};
        `SLCD_OFS_STATUS: begin
          slcd_read = 32'h00000000;
          slcd_read[`SLCD_STATUS_POS_LSB +: 6] = pos_cap;
          slcd_read[`SLCD_STATUS_NEG_LSB +: 6] = neg_cap;
          slcd_read[`SLCD_STATUS_INV_FIXED] = fixed_bad;
          slcd_read[`SLCD_STATUS_INV_CHARGE] = charge_bad;
          slcd_read[`SLCD_STATUS_INV_MODE] = !mode_ok;
          slcd_read[`SLCD_STATUS_INVALID] = strap_invalid;
          slcd_read[`SLCD_STATUS_CAPTURED] = config_captured;
          slcd_read[`SLCD_STATUS_PFSEL_LSB +: 2] = pf_config_sel;
        end
        `SLCD_OFS_DECODE: begin
          slcd_read = 32'h00000000;
          slcd_read[`SLCD_DECODE_DIS_LSB +: 6] = port_disable;
          slcd_read[`SLCD_DECODE_SS_LSB +: 6] = port_ss_disable;
          slcd_read[`SLCD_DECODE_FIXED_LSB +: 6] = fixed_port_mask;
          slcd_read[`SLCD_DECODE_CHARGE_LSB +: 6] = charge_port_mask;
        end
        `SLCD_OFS_LEVELS: begin
          slcd_read = 32'h00000000;
          slcd_read[`SLCD_LEVELS_FIXED_LSB +: 3] = fixed_cap;
          slcd_read[`SLCD_LEVELS_CHARGE_LSB +: 3] = charge_cap;
          slcd_read[`SLCD_LEVELS_MODE1_LSB +: 3] = mode1_cap;
          slcd_read[`SLCD_LEVELS_MODE2_LSB +: 3] = mode2_cap;
        end
        default: slcd_read = 32'h00000000;
      endcase
    end
  endfunction

  // Address phase: note writes, register read data for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      // Writes complete in the next cycle, when hwdata stands
      wr_pending <= accept && hwrite && mapped;
      wr_addr <= req_addr;
      if (accept && !hwrite && mapped) begin
        hrdata <= slcd_read(req_addr);
      end else begin
        hrdata <= 32'h00000000; // Unmapped reads as zero
      end
    end
  end

  // Data phase: only the control word is writable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_disable <= `SLCD_CTRL_RESET;
    end else if (wr_pending && wr_addr == `SLCD_OFS_CTRL) begin
      // Only the low six bits are kept; others read zero
      force_disable <= hwdata[5:0];
    end
  end

endmodule
`default_nettype wire

// ### core/slcd_consts.vh
// Constants for the strap latch and configuration decoder
`ifndef SLCD_CONSTS_VH
`define SLCD_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SLCD_OFS_CTRL 8'h00
`define SLCD_OFS_STATUS 8'h04
`define SLCD_OFS_DECODE 8'h08
`define SLCD_OFS_LEVELS 8'h0C

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SLCD_CTRL_RESET 6'h00
`define SLCD_MASK_RESET 6'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SLCD_STATUS_POS_LSB 0
`define SLCD_STATUS_NEG_LSB 8
`define SLCD_STATUS_INV_FIXED 16
`define SLCD_STATUS_INV_CHARGE 17
`define SLCD_STATUS_INV_MODE 18
`define SLCD_STATUS_INVALID 19
`define SLCD_STATUS_CAPTURED 20
`define SLCD_STATUS_PFSEL_LSB 24
`define SLCD_DECODE_DIS_LSB 0
`define SLCD_DECODE_SS_LSB 8
`define SLCD_DECODE_FIXED_LSB 16
`define SLCD_DECODE_CHARGE_LSB 24
`define SLCD_LEVELS_FIXED_LSB 0
`define SLCD_LEVELS_CHARGE_LSB 4
`define SLCD_LEVELS_MODE1_LSB 8
`define SLCD_LEVELS_MODE2_LSB 12

// ------------------------------------------------------------
// Decoded resistor level indices
// ------------------------------------------------------------
`define SLCD_LVL_200K_DOWN 3'h0
`define SLCD_LVL_200K_UP 3'h1
`define SLCD_LVL_10K_DOWN 3'h2
`define SLCD_LVL_10K_UP 3'h3
`define SLCD_LVL_10R_DOWN 3'h4
`define SLCD_LVL_10R_UP 3'h5

// ------------------------------------------------------------
// Pin function configuration codes
// ------------------------------------------------------------
`define SLCD_PFSEL_NONE 2'h0
`define SLCD_PFSEL_CONFIG3 2'h3

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define SLCD_SETTLE_CYCLES 3'h4

`endif

// ### core/slcd_sync.v
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module slcd_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] held
);

  reg [WIDTH-1:0] stage1; // Only read by stage2
  reg [WIDTH-1:0] stage2; // Second flop
  reg [WIDTH-1:0] stage3; // Third flop

  // ------------------------------------------------------------
  // Shift chain; held value moves only when stage2 and stage3 agree
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      held <= INIT;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        held <= stage3;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/slcd_level_decode.v
// Resistor level index to port count mask decoder
`timescale 1ns/100ps
`default_nettype none
`include "slcd_consts.vh"

module slcd_level_decode (
  input wire [2:0] level,
  output wire [5:0] port_mask,
  output wire invalid
);

  // ------------------------------------------------------------
  // Thermometer mask from level; reserved codes give no ports
  // ------------------------------------------------------------
  function [6:0] slcd_mask;
    input [2:0] lvl;
    begin
      case (lvl)
        `SLCD_LVL_200K_DOWN: slcd_mask = 7'h00;
        `SLCD_LVL_200K_UP: slcd_mask = 7'h01;
        `SLCD_LVL_10K_DOWN: slcd_mask = 7'h03;
        `SLCD_LVL_10K_UP: slcd_mask = 7'h07;
        `SLCD_LVL_10R_DOWN: slcd_mask = 7'h0F;
        `SLCD_LVL_10R_UP: slcd_mask = 7'h3F;
        default: slcd_mask = 7'h40;
      endcase
    end
  endfunction

  wire [6:0] decoded; // Invalid flag over six port bits

  assign decoded = slcd_mask(level);
  assign port_mask = decoded[5:0];
  assign invalid = decoded[6];

endmodule
`default_nettype wire

// ### bench/slcd_strap_board.sv
// Board strap resistor model presenting sensed strap levels
`timescale 1ns/100ps
`default_nettype none
module slcd_strap_board (
  input wire logic [5:0] pos_pull,
  input wire logic [5:0] neg_pull,
  input wire logic [2:0] fix_res,
  input wire logic [2:0] chg_res,
  input wire logic [2:0] m1_res,
  input wire logic [2:0] m2_res,
  output logic [5:0] port_pos_line_disable_strap,
  output logic [5:0] port_neg_line_disable_strap,
  output logic [2:0] fixed_port_count_strap,
  output logic [2:0] charge_port_count_strap,
  output logic [2:0] mode_strap1_level,
  output logic [2:0] mode_strap2_level
);
  // Third mode strap, held by its pull-down and never wired in
  logic [2:0] mode_strap3_level;
  assign mode_strap3_level = 3'h0;
  // Data line ties, a one is a tie to the supply rail
  assign port_pos_line_disable_strap = pos_pull;
  assign port_neg_line_disable_strap = neg_pull;
  // Sensed resistor level 0 to 5, reserved codes only on command
  assign fixed_port_count_strap = fix_res;
  assign charge_port_count_strap = chg_res;
  // Lower mode pair, the supported pair unless told otherwise
  assign mode_strap1_level = m1_res;
  assign mode_strap2_level = m2_res;
endmodule
`default_nettype wire

// ### bench/slcd_strap_latch_sva.sv
// Assertion checker for the strap latch outputs
`timescale 1ns/100ps
`default_nettype none
module slcd_strap_latch_sva (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire ext_reset_n,
  input wire [5:0] port_pos_line_disable_strap,
  input wire [5:0] port_neg_line_disable_strap,
  input wire [2:0] fixed_port_count_strap,
  input wire [2:0] charge_port_count_strap,
  input wire [2:0] mode_strap1_level,
  input wire [2:0] mode_strap2_level,
  input wire [5:0] port_disable,
  input wire [5:0] port_ss_disable,
  input wire [5:0] fixed_port_mask,
  input wire [5:0] charge_port_mask,
  input wire [1:0] pf_config_sel,
  input wire strap_invalid,
  input wire config_captured
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] quiet_cnt; // Cycles since external reset was last low
  logic pair_ok; // Supported lower mode pair
  logic lvl_bad; // Reserved count level
  assign pair_ok = (mode_strap2_level == 3'h0) && (mode_strap1_level == 3'h2);
  assign lvl_bad = (fixed_port_count_strap > 3'h5) || (charge_port_count_strap > 3'h5);
  // Level index to thermometer mask of ports
  function automatic logic [5:0] exp_mask(input logic [2:0] l);
    exp_mask = (l == 3'h5) ? 6'h3F : (l > 3'h5) ? 6'h00 : ((6'h01 << l) - 6'h01);
  endfunction
  // Quiet time counter, saturates at fifteen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_cnt <= 4'h0;
    end else if (!ext_reset_n) begin
      quiet_cnt <= 4'h0;
    end else if (quiet_cnt != 4'hF) begin
      quiet_cnt <= quiet_cnt + 4'h1;
    end
  end
  // Settle window, then the captured flag comes up
  sequence settle_s;
    (!config_captured) [*4] ##[1:6] config_captured;
  endsequence
  // First cycle of the captured flag after chip reset; later external reset captures do not rise it
  sequence cap_s;
    $rose(config_captured);
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave waited or answered an error");
  ss_follow_a: assert property (port_ss_disable == port_disable)
    else $error("superspeed disable differs from port disable");
  fixed_shape_a: assert property (fixed_port_mask inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F})
    else $error("fixed port mask is not a legal setting");
  charge_shape_a: assert property (charge_port_mask inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F})
    else $error("charge port mask is not a legal setting");
  capture_time_a: assert property ($rose(hresetn) |-> settle_s)
    else $error("capture after reset release late or early");
  capture_hold_a: assert property (config_captured |=> config_captured)
    else $error("captured flag dropped without reset");
  cap_count_a: assert property (cap_s |=> fixed_port_mask == exp_mask(fixed_port_count_strap) && charge_port_mask == exp_mask(charge_port_count_strap))
    else $error("count masks wrong at capture");
  cap_port_a: assert property (cap_s |=> port_disable == (port_pos_line_disable_strap & port_neg_line_disable_strap))
    else $error("port disable wrong at capture");
  cap_mode_a: assert property (cap_s |=> pf_config_sel == (pair_ok ? 2'h3 : 2'h0) && strap_invalid == (lvl_bad || !pair_ok))
    else $error("pin function select or invalid flag wrong");
  quiet_hold_a: assert property (quiet_cnt == 4'hF && config_captured |=> $stable(fixed_port_mask) && $stable(charge_port_mask) && $stable(pf_config_sel))
    else $error("decoded settings moved between captures");
  // Pin rise, three flops, filter flop, capture, then registered decode
  ext_capture_a: assert property ($rose(ext_reset_n) |-> ##6 fixed_port_mask == exp_mask(fixed_port_count_strap) && charge_port_mask == exp_mask(charge_port_count_strap))
    else $error("count masks wrong after external reset release");
endmodule
`default_nettype wire

// ### bench/slcd_strap_latch_test.sv
// Self-checking bench for the strap latch and decoder
`timescale 1ns/100ps
`default_nettype none
`include "slcd_consts.vh"
module slcd_strap_latch_test;
  logic hclk, hresetn, hsel, hwrite, ext_reset_n;
  logic [1:0] htrans;
  logic [2:0] hsize, fix_res, chg_res, m1_res, m2_res;
  logic [5:0] pos_pull, neg_pull;
  logic [31:0] haddr, hwdata, rd;
  wire hreadyout, hresp, hready, strap_invalid, config_captured;
  wire [31:0] hrdata;
  wire [5:0] port_pos_line_disable_strap, port_neg_line_disable_strap;
  wire [2:0] fixed_port_count_strap, charge_port_count_strap, mode_strap1_level, mode_strap2_level;
  wire [5:0] port_disable, port_ss_disable, fixed_port_mask, charge_port_mask;
  wire [1:0] pf_config_sel;
  int num_errors, total_checks, i;
  logic [2:0] lv;
  assign hready = hreadyout; // Single slave drives the bus ready
  slcd_strap_board board (.pos_pull, .neg_pull, .fix_res, .chg_res, .m1_res, .m2_res, .port_pos_line_disable_strap,
    .port_neg_line_disable_strap, .fixed_port_count_strap, .charge_port_count_strap, .mode_strap1_level, .mode_strap2_level);
  slcd_strap_latch dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .ext_reset_n, .port_pos_line_disable_strap, .port_neg_line_disable_strap, .fixed_port_count_strap,
    .charge_port_count_strap, .mode_strap1_level, .mode_strap2_level, .port_disable, .port_ss_disable, .fixed_port_mask,
    .charge_port_mask, .pf_config_sel, .strap_invalid, .config_captured);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Level index to thermometer mask of ports
  function automatic logic [5:0] exp_mask(input logic [2:0] l);
    exp_mask = (l == 3'h5) ? 6'h3F : (l > 3'h5) ? 6'h00 : ((6'h01 << l) - 6'h01);
  endfunction
  // Verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Register result compare
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Output pin compare
  task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
    chk_reg({26'h0, got}, {26'h0, exp});
  endtask
  // Single AHB-Lite transfer, read data left in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Board resistor choice
  task automatic straps(input logic [5:0] p, input logic [5:0] n, input logic [2:0] f, input logic [2:0] c,
    input logic [2:0] m1, input logic [2:0] m2);
    pos_pull <= p;
    neg_pull <= n;
    fix_res <= f;
    chg_res <= c;
    m1_res <= m1;
    m2_res <= m2;
  endtask
  // Chip reset, then settle
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
  // External reset pulse, then settle
  task automatic ext_pulse;
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge hclk);
    ext_reset_n <= 1'b1;
    repeat (14) @(posedge hclk);
  endtask
  // All decoded outputs
  task automatic chk_outs(input logic [5:0] dis, input logic [5:0] fm, input logic [5:0] cm, input logic [1:0] pf,
    input logic inv);
    chk_pin(port_disable, dis);
    chk_pin(port_ss_disable, dis);
    chk_pin(fixed_port_mask, fm);
    chk_pin(charge_port_mask, cm);
    chk_pin({4'h0, pf_config_sel}, {4'h0, pf});
    chk_pin({5'h0, strap_invalid}, {5'h0, inv});
    chk_pin({5'h0, config_captured}, 6'h01);
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    complete_run;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    ext_reset_n = 1'b1;
    straps(6'h2D, 6'h39, 3'h3, 3'h5, 3'h2, 3'h0);
    do_reset;
    chk_outs(6'h29, 6'h07, 6'h3F, 2'h3, 1'b0);
    bus(1'b0, `SLCD_OFS_STATUS, 32'h0);
    chk_reg(rd, 32'h0310392D);
    bus(1'b0, `SLCD_OFS_DECODE, 32'h0);
    chk_reg(rd, 32'h3F072929);
    bus(1'b0, `SLCD_OFS_LEVELS, 32'h0);
    chk_reg(rd, 32'h00000253);
    bus(1'b1, `SLCD_OFS_CTRL, 32'h00000012);
    bus(1'b1, `SLCD_OFS_DECODE, 32'hFFFFFFFF);
    bus(1'b0, `SLCD_OFS_DECODE, 32'h0);
    chk_reg(rd, 32'h3F073B3B);
    bus(1'b0, 32'h00000100, 32'h0);
    chk_reg(rd, 32'h0);
    straps(6'h3F, 6'h3F, 3'h5, 3'h0, 3'h2, 3'h1);
    repeat (12) @(posedge hclk);
    chk_outs(6'h3B, 6'h07, 6'h3F, 2'h3, 1'b0);
    bus(1'b1, `SLCD_OFS_CTRL, 32'h0);
    ext_pulse;
    chk_outs(6'h3F, 6'h3F, 6'h00, 2'h0, 1'b1);
    for (i = 0; i < 8; i++) begin
      lv = i[2:0];
      straps(6'h00, 6'h3F, lv, 3'h7 - lv, (lv == 3'h6) ? 3'h3 : 3'h2, (lv == 3'h4) ? 3'h1 : 3'h0);
      ext_pulse;
      chk_outs(6'h00, exp_mask(lv), exp_mask(3'h7 - lv), (lv == 3'h4 || lv == 3'h6) ? 2'h0 : 2'h3,
        lv < 3'h3 && lv != 3'h2 || lv > 3'h5 || lv == 3'h4);
    end
    bus(1'b1, `SLCD_OFS_CTRL, 32'h0000003F);
    straps(6'h2D, 6'h39, 3'h3, 3'h5, 3'h2, 3'h0);
    do_reset;
    chk_outs(6'h29, 6'h07, 6'h3F, 2'h3, 1'b0);
    bus(1'b0, `SLCD_OFS_CTRL, 32'h0);
    chk_reg(rd, 32'h0);
    complete_run;
  end
endmodule
bind slcd_strap_latch slcd_strap_latch_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp, .ext_reset_n,
  .port_pos_line_disable_strap, .port_neg_line_disable_strap, .fixed_port_count_strap, .charge_port_count_strap,
  .mode_strap1_level, .mode_strap2_level, .port_disable, .port_ss_disable, .fixed_port_mask, .charge_port_mask,
  .pf_config_sel, .strap_invalid, .config_captured);
`default_nettype wire
